// *** src/kbc_fifo.sv ***
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: single clock, DEPTH a power of two
// Notes: full and empty are exact; no write when full, no read when empty
`default_nettype none
module kbc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic [WIDTH-1:0] in_data_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   output logic [WIDTH-1:0] out_data_out,
   output logic out_valid_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];  // storage
   logic [AW:0] wr_ptr;  // write pointer with wrap bit
   logic [AW:0] rd_ptr;  // read pointer with wrap bit
   logic push;
   logic pop;

   // full when pointers differ only in wrap bit
   assign in_ready_out = (wr_ptr != {~rd_ptr[AW], rd_ptr[AW-1:0]});
   assign out_valid_out = (wr_ptr != rd_ptr);
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem[rd_ptr[AW-1:0]];

   // storage write
   always_ff @(posedge core_clk_in) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_in;
      end
   end

   // pointer update
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** src/kbc_host_channel.sv ***
// Purpose: keyboard/mouse host channel between a host I/O port pair and the embedded core
// Assumes: all strobes synchronous to core_clk_in, one-cycle read/write strobes
// Notes: host writes queue in a fifo ahead of the input latch
//        host back-pressure is the fifo ready
// Operation
// - host write latches byte, sets full, records address
// - core input read clears input-full flag
// - input-full core interrupt level when enabled
// - keyboard port write fills latch, raises keyboard line
// - mouse port write fills latch, raises mouse line
// - in hardware mode only last-written port's host line follows output-full
// - host data read returns latch, clears output-full
// - normal polarity: low idle, high while full
// - invert bit flips hardware-driven host lines
// - hardware disabled: line follows firmware level bit
// - level bits read back present line values
// - output-empty core interrupt high while not full
// - status bits 2,4-7 core writable only
// - host and core see same status byte
// - data/command ports programmable, legacy defaults
// - core interrupts are levels, never pulses
// - status byte resets to zero
// - irq control resets to 07h
`default_nettype none
`include "kbc_regs.svh"
module kbc_host_channel #(
   parameter logic [15:0] DATA_PORT = `KBC_HOST_DATA_PORT,  // host data/output address
   parameter logic [15:0] CMD_PORT = `KBC_HOST_CMD_PORT,  // host command/status address
   parameter int FIFO_DEPTH = `KBC_FIFO_DEPTH  // queued host writes
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // host I/O cycle port
   // writes stall while ready is low
   input wire logic [15:0] host_addr_in,
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire kbc_pkg::kbc_byte_t host_wdata_in,
   output kbc_pkg::kbc_byte_t host_rdata_out,
   output logic host_rvalid_out,
   output logic host_wr_ready_out,
   // core register port
   // read data one cycle later
   input wire logic [7:0] core_addr_in,
   input wire logic core_wr_in,
   input wire logic core_rd_in,
   input wire kbc_pkg::kbc_byte_t core_wdata_in,
   output kbc_pkg::kbc_byte_t core_rdata_out,
   // interrupts
   // all four are levels
   output logic core_infull_irq_out,
   output logic core_outempty_irq_out,
   output logic keyboard_host_irq_out,
   output logic mouse_host_irq_out
);
   import kbc_pkg::*;

   // latches and registers
   // all cleared by the core reset except irq control, which loads 07h
   kbc_byte_t host_input_latch;  // byte for the core
   kbc_byte_t host_output_latch;  // byte for the host
   kbc_byte_t status;  // shared status byte
   logic [3:0] general_flags_upper;  // core-owned bits 7 to 4
   logic general_flag_zero;  // core-owned bit 2
   kbc_byte_t host_if_control;  // enables
   kbc_byte_t host_irq_control;  // levels and polarity
   kbc_src_t last_src;  // port that last filled the output latch

   // hardware-owned status flags
   logic input_full_flag;
   logic output_full_flag;
   logic last_write_was_command;

   // decoded fields
   logic infull_core_irq_en;
   logic outempty_core_irq_en;
   logic kbd_host_irq_en;
   logic aux_host_irq_en;
   logic host_irq_invert;
   logic kbd_irq_level_bit;
   logic aux_irq_level_bit;

   // host decode
   // against the two chip selects
   logic host_sel_data;  // chip select on data address
   logic host_sel_cmd;  // chip select on command address
   logic host_push;  // host write taken into fifo
   logic host_data_read;  // host read of output latch

   // core decode
   // strobes are one cycle wide
   logic kbd_out_write_port;  // write strobe to keyboard output port
   logic aux_out_write_port;  // write strobe to mouse output port
   logic core_input_read_port;  // read strobe to input latch
   logic core_status_view_wr;  // write strobe to status view
   logic core_ctrl_wr;  // write strobe to interface control
   logic core_irqc_wr;  // write strobe to irq control
   logic out_write;  // either output port written

   // fifo wiring
   // byte and marker travel together
   kbc_entry_t fifo_out;  // {command marker, byte}
   logic fifo_valid;
   logic fifo_pop;  // move head into input latch

   // host line values before and after override
   // steered by the last output port
   logic kbd_hw_level;
   logic aux_hw_level;

   // status byte gathered from its owners
   assign status = {general_flags_upper, last_write_was_command, general_flag_zero,
                    input_full_flag, output_full_flag};
   // control register fields
   assign infull_core_irq_en = host_if_control[`KBC_CT_IBF_EN];
   assign outempty_core_irq_en = host_if_control[`KBC_CT_OBE_EN];
   assign kbd_host_irq_en = host_if_control[`KBC_CT_KBD_EN];
   assign aux_host_irq_en = host_if_control[`KBC_CT_AUX_EN];
   assign host_irq_invert = host_irq_control[`KBC_IQ_INVERT];
   assign kbd_irq_level_bit = host_irq_control[`KBC_IQ_KBD_LVL];
   assign aux_irq_level_bit = host_irq_control[`KBC_IQ_AUX_LVL];

   // host address decode against the programmable chip selects
   // other addresses are ignored
   assign host_sel_data = (host_addr_in == DATA_PORT);
   assign host_sel_cmd = (host_addr_in == CMD_PORT);
   assign host_push = host_wr_in && (host_sel_data || host_sel_cmd) && host_wr_ready_out;
   assign host_data_read = host_rd_in && host_sel_data;

   // core register decode
   // unmapped offsets raise no strobe
   assign kbd_out_write_port = core_wr_in && (core_addr_in == `KBC_OFS_KBD_OUT);
   assign aux_out_write_port = core_wr_in && (core_addr_in == `KBC_OFS_AUX_OUT);
   assign core_input_read_port = core_rd_in && (core_addr_in == `KBC_OFS_INPUT_READ);
   assign core_status_view_wr = core_wr_in && (core_addr_in == `KBC_OFS_STATUS_VIEW);
   assign core_ctrl_wr = core_wr_in && (core_addr_in == `KBC_OFS_IF_CONTROL);
   assign core_irqc_wr = core_wr_in && (core_addr_in == `KBC_OFS_IRQ_CONTROL);
   assign out_write = kbd_out_write_port || aux_out_write_port;

   // head of queue moves into the latch only while the latch is empty,
   // so a core read clearing the flag never meets a load in the same cycle
   assign fifo_pop = fifo_valid && !input_full_flag;

   // host write queue; its ready is the host's back-pressure
   // a stalled host holds its write
   // order is kept through the queue
   kbc_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH)
   ) u_in_fifo (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .in_data_in({host_sel_cmd, host_wdata_in}),
      .in_valid_in(host_wr_in && (host_sel_data || host_sel_cmd)),
      .in_ready_out(host_wr_ready_out),
      .out_data_out(fifo_out),
      .out_valid_out(fifo_valid),
      .out_ready_in(!input_full_flag)
   );

   // input latch loaded from the queue head
   // byte stays after the core reads it
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         host_input_latch <= 8'h00;
      end else if (fifo_pop) begin
         host_input_latch <= fifo_out[7:0];
      end
   end

   // output latch written from either output port
   // a write while full overwrites
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         host_output_latch <= 8'h00;
      end else if (kbd_out_write_port) begin
         host_output_latch <= core_wdata_in;
      end else if (aux_out_write_port) begin
         host_output_latch <= core_wdata_in;
      end
   end

   // remember which output port was written last
   // keyboard owns the flag after reset
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         last_src <= kbc_src_kbd;
      end else if (kbd_out_write_port) begin
         last_src <= kbc_src_kbd;
      end else if (aux_out_write_port) begin
         last_src <= kbc_src_aux;
      end
   end

   // general purpose status bits, core writable only
   // hardware-owned bits have no write path
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         general_flags_upper <= 4'h0;
         general_flag_zero <= 1'b0;
      end else if (core_status_view_wr) begin
         general_flags_upper <= core_wdata_in[7:4];
         general_flag_zero <= core_wdata_in[`KBC_ST_FLAG0];
      end
   end

   // input-full flag: load sets, core input read clears
   // a load waits for empty, so both never meet
   // a read of an empty latch changes nothing
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         input_full_flag <= 1'b0;
      end else if (fifo_pop) begin
         input_full_flag <= 1'b1;
      end else if (core_input_read_port) begin
         input_full_flag <= 1'b0;
      end
   end

   // command marker of the byte in the input latch
   // only a load changes it
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         last_write_was_command <= 1'b0;
      end else if (fifo_pop) begin
         last_write_was_command <= fifo_out[8];
      end
   end

   // output-full flag: core write sets and wins over a host read clear
   // so a fresh byte is never lost
   // reads at the command address leave it
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         output_full_flag <= 1'b0;
      end else if (out_write) begin
         output_full_flag <= 1'b1;
      end else if (host_data_read) begin
         output_full_flag <= 1'b0;
      end
   end

   // interface control register; reserved bit 7 stays zero
   // bits 4 to 6 steer nothing here
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         host_if_control <= `KBC_CT_RESET;
      end else if (core_ctrl_wr) begin
         host_if_control <= core_wdata_in & `KBC_CT_WR_MASK;
      end
   end

   // irq control register; reserved bits stay zero
   // bit 6 inverts hardware lines only
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         host_irq_control <= `KBC_IQ_RESET;
      end else if (core_irqc_wr) begin
         host_irq_control <= core_wdata_in & `KBC_IQ_WR_MASK;
      end
   end

   // hardware level: only the line of the last written port follows the flag
   // the shared flag reaches one line
   // so with invert clear both hardware-driven lines never rise together
   assign kbd_hw_level = output_full_flag && (last_src == kbc_src_kbd);
   assign aux_hw_level = output_full_flag && (last_src == kbc_src_aux);

   // keyboard line: hardware with optional inversion, else firmware level
   // firmware levels are never inverted
   always_comb begin
      if (kbd_host_irq_en) begin
         keyboard_host_irq_out = kbd_hw_level ^ host_irq_invert;
      end else begin
         keyboard_host_irq_out = kbd_irq_level_bit;
      end
   end

   // mouse line: same scheme, own enable
   // shares the invert bit with the keyboard
   always_comb begin
      if (aux_host_irq_en) begin
         mouse_host_irq_out = aux_hw_level ^ host_irq_invert;
      end else begin
         mouse_host_irq_out = aux_irq_level_bit;
      end
   end

   // core interrupts are plain levels from the flags
   // no edge detection on either
   assign core_infull_irq_out = infull_core_irq_en && input_full_flag;
   assign core_outempty_irq_out = outempty_core_irq_en && !output_full_flag;

   // host read data, registered one cycle after the strobe
   // other reads keep the last answer
   // status shows flags at the strobe edge
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         host_rdata_out <= 8'h00;
      end else if (host_rd_in && host_sel_data) begin
         host_rdata_out <= host_output_latch;
      end else if (host_rd_in && host_sel_cmd) begin
         host_rdata_out <= status;
      end
   end

   // read data valid marker
   // high one cycle per decoded read
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         host_rvalid_out <= 1'b0;
      end else begin
         host_rvalid_out <= host_rd_in && (host_sel_data || host_sel_cmd);
      end
   end

   // core read data, registered; unmapped and write-only offsets read zero
   // held until the next core read
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         core_rdata_out <= 8'h00;
      end else if (core_rd_in) begin
         unique case (core_addr_in)
            `KBC_OFS_IF_CONTROL: begin
               core_rdata_out <= host_if_control;
            end
            `KBC_OFS_IRQ_CONTROL: begin
               core_rdata_out <= {host_irq_control[7:2], mouse_host_irq_out,
                                  keyboard_host_irq_out};
            end
            `KBC_OFS_STATUS_VIEW: begin
               core_rdata_out <= status;
            end
            `KBC_OFS_INPUT_READ: begin
               core_rdata_out <= host_input_latch;
            end
            default: begin
               core_rdata_out <= 8'h00;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** src/kbc_pkg.sv ***
// Purpose: shared types of the kbc host channel
// Assumes: nothing beyond plain logic types
// Notes: constants live in kbc_regs.svh
`default_nettype none
package kbc_pkg;
   // one byte on either port
   typedef logic [7:0] kbc_byte_t;
   // a queued host write: command marker above the byte
   typedef logic [8:0] kbc_entry_t;
   // which output write port last filled the output latch
   typedef enum logic {kbc_src_kbd, kbc_src_aux} kbc_src_t;
endpackage
`default_nettype wire

// *** src/kbc_regs.svh ***
// Purpose: offsets, field positions, reset values and legacy ports of the kbc host channel
// Assumes: core register offsets are the low byte of the core peripheral address
// Notes: included by its bare name, definitions only
`ifndef KBC_REGS_SVH
`define KBC_REGS_SVH

// core-side register byte offsets
`define KBC_OFS_IF_CONTROL 8'h80
`define KBC_OFS_IRQ_CONTROL 8'h82
`define KBC_OFS_STATUS_VIEW 8'h84
`define KBC_OFS_KBD_OUT 8'h86
`define KBC_OFS_AUX_OUT 8'h88
`define KBC_OFS_INPUT_READ 8'h8a

// legacy host chip select addresses
`define KBC_HOST_DATA_PORT 16'h0060
`define KBC_HOST_CMD_PORT 16'h0064

// status byte fields
`define KBC_ST_OUT_FULL 0
`define KBC_ST_IN_FULL 1
`define KBC_ST_FLAG0 2
`define KBC_ST_CMD 3
`define KBC_ST_WR_MASK 8'hf4
`define KBC_ST_RESET 8'h00

// interface control fields
`define KBC_CT_KBD_EN 0
`define KBC_CT_AUX_EN 1
`define KBC_CT_OBE_EN 2
`define KBC_CT_IBF_EN 3
`define KBC_CT_WR_MASK 8'h7f
`define KBC_CT_RESET 8'h00

// irq control fields
`define KBC_IQ_KBD_LVL 0
`define KBC_IQ_AUX_LVL 1
`define KBC_IQ_INVERT 6
`define KBC_IQ_WR_MASK 8'h47
`define KBC_IQ_RESET 8'h07

// input fifo depth
`define KBC_FIFO_DEPTH 8

`endif

// *** testbench/kbc_host_channel_bench.sv ***
// Purpose: self-checking bench of the kbc host channel
// Assumes: core cycles from rising-edge tasks, host cycles from the model
// Notes: random bytes from a fixed-seed shift register
`default_nettype none
`include "kbc_regs.svh"
module kbc_host_channel_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import kbc_pkg::*;
   logic core_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [15:0] host_addr_in;
   logic host_wr_in, host_rd_in, host_rvalid_out, host_wr_ready_out;
   kbc_byte_t host_wdata_in, host_rdata_out, core_wdata_in, core_rdata_out;
   logic [7:0] core_addr_in = 8'h00;
   logic core_wr_in = 1'b0;
   logic core_rd_in = 1'b0;
   logic core_infull_irq_out, core_outempty_irq_out, keyboard_host_irq_out, mouse_host_irq_out;
   logic [31:0] seed = 32'h023e33f6; // fixed seed
   int bad_count = 0;
   int samples_checked = 0;
   always #20 core_clk_in = ~core_clk_in; // 25 MHz
   kbc_host_channel kbc_host_channel_inst (.core_clk_in, .reset_n_in, .host_addr_in,
      .host_wr_in, .host_rd_in, .host_wdata_in, .host_rdata_out, .host_rvalid_out,
      .host_wr_ready_out, .core_addr_in, .core_wr_in, .core_rd_in, .core_wdata_in,
      .core_rdata_out, .core_infull_irq_out, .core_outempty_irq_out,
      .keyboard_host_irq_out, .mouse_host_irq_out);
   kbc_host_model kbc_host_model_inst (.core_clk_in, .host_addr_out(host_addr_in),
      .host_wr_out(host_wr_in), .host_rd_out(host_rd_in), .host_wdata_out(host_wdata_in),
      .host_rdata_in(host_rdata_out), .host_rvalid_in(host_rvalid_out),
      .host_wr_ready_in(host_wr_ready_out));
   // step the shift register, low byte out
   function automatic kbc_byte_t rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   // irq control readback: invert, bit2, live lines
   function automatic kbc_byte_t irqc_exp(logic inv, logic aux, logic kbd);
      return {1'b0, inv, 4'h1, aux, kbd};
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // a wait that ran out ends the run
   task automatic need(input logic ok);
      check(ok, 1'b1);
      if (ok !== 1'b1) give_verdict();
   endtask
   task automatic cwr(input logic [7:0] a, input kbc_byte_t d);
      @(posedge core_clk_in);
      core_addr_in <= a;
      core_wdata_in <= d;
      core_wr_in <= 1'b1;
      @(posedge core_clk_in);
      core_wr_in <= 1'b0;
      #1;
   endtask
   task automatic crd(input logic [7:0] a, output kbc_byte_t d);
      @(posedge core_clk_in);
      core_addr_in <= a;
      core_rd_in <= 1'b1;
      @(posedge core_clk_in);
      core_rd_in <= 1'b0;
      #1 d = core_rdata_out;
   endtask
   task automatic creq(input logic [7:0] a, input kbc_byte_t exp);
      kbc_byte_t d;
      crd(a, d);
      check(d, exp);
   endtask
   initial begin
      kbc_byte_t d, e, sv;
      kbc_byte_t b [10];
      logic ok, p;
      int i, k, n;
      core_wdata_in = 8'h00;
      repeat (2) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      check({keyboard_host_irq_out, mouse_host_irq_out}, 2'b11);
      creq(`KBC_OFS_STATUS_VIEW, 8'h00);
      creq(`KBC_OFS_IRQ_CONTROL, 8'h07);
      creq(8'h8c, 8'h00); // unmapped offset reads zero
      for (i = 0; i < 4; i++) begin // firmware levels, random invert
         d = rnd() & 8'h44 | i[7:0];
         cwr(`KBC_OFS_IRQ_CONTROL, d);
         check({mouse_host_irq_out, keyboard_host_irq_out}, d[1:0]);
         creq(`KBC_OFS_IRQ_CONTROL, d);
      end
      sv = rnd() | 8'h0b; // hardware bits must not take
      cwr(`KBC_OFS_STATUS_VIEW, sv);
      sv = sv & 8'hf4;
      creq(`KBC_OFS_STATUS_VIEW, sv);
      kbc_host_model_inst.get(`KBC_HOST_CMD_PORT, e, ok);
      check(e, sv);
      kbc_host_model_inst.get(16'h0061, e, ok);
      check(ok, 1'b0);
      cwr(`KBC_OFS_IF_CONTROL, 8'h08);
      for (i = 0; i < 10; i++) b[i] = rnd();
      fork
         for (k = 0; k < 10; k++) begin // alternate data and command port
            kbc_host_model_inst.put(k[0] ? `KBC_HOST_CMD_PORT : `KBC_HOST_DATA_PORT, b[k], ok);
            need(ok);
         end
         begin
            repeat (40) @(posedge core_clk_in);
            #1 check(host_wr_ready_out, 1'b0); // latch and fifo full
            for (i = 0; i < 10; i++) begin
               for (n = 0; n < 40 && core_infull_irq_out !== 1'b1; n++) #40;
               need(core_infull_irq_out);
               creq(`KBC_OFS_STATUS_VIEW, sv | {4'h0, i[0], 3'b010});
               creq(`KBC_OFS_INPUT_READ, b[i]);
               check(core_infull_irq_out, 1'b0);
            end
         end
      join
      cwr(`KBC_OFS_IF_CONTROL, 8'h07);
      kbc_host_model_inst.idle_cycles = 2; // slow host
      for (i = 0; i < 4; i++) begin // both ports, both polarities
         p = i[0];
         cwr(`KBC_OFS_IRQ_CONTROL, {1'b0, i[1], 6'h07});
         check({keyboard_host_irq_out, mouse_host_irq_out}, {2{i[1]}});
         d = rnd();
         cwr(p ? `KBC_OFS_AUX_OUT : `KBC_OFS_KBD_OUT, d);
         check(keyboard_host_irq_out, i[1] ^ !p);
         check(mouse_host_irq_out, i[1] ^ p);
         check(core_outempty_irq_out, 1'b0);
         creq(`KBC_OFS_IRQ_CONTROL, irqc_exp(i[1], i[1] ^ p, i[1] ^ !p));
         kbc_host_model_inst.fetch(e, ok);
         need(ok);
         check(e, d);
         check({keyboard_host_irq_out, mouse_host_irq_out}, {2{i[1]}});
         check(core_outempty_irq_out, 1'b1);
      end
      give_verdict();
   end
endmodule
`default_nettype wire

// *** testbench/kbc_host_channel_props.sv ***
// Purpose: port-level checks of the kbc host channel
// Assumes: one clock, async active-low reset
// Notes: enable, invert and level bits shadowed from core writes
`default_nettype none
`include "kbc_regs.svh"
module kbc_host_channel_props #(
   parameter logic [15:0] DATA_PORT = `KBC_HOST_DATA_PORT,
   parameter logic [15:0] CMD_PORT = `KBC_HOST_CMD_PORT
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic [15:0] host_addr_in,
   input wire logic host_rd_in,
   input wire logic host_rvalid_out,
   input wire logic [7:0] core_addr_in,
   input wire logic core_wr_in,
   input wire logic core_rd_in,
   input wire kbc_pkg::kbc_byte_t core_wdata_in,
   input wire logic core_infull_irq_out,
   input wire logic core_outempty_irq_out,
   input wire logic keyboard_host_irq_out,
   input wire logic mouse_host_irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import kbc_pkg::*;
   logic [3:0] ctl; // shadow enables
   logic inv; // shadow invert bit
   logic [1:0] lvl; // shadow firmware levels
   wire logic hrd = host_rd_in && host_addr_in == DATA_PORT; // host data read
   wire logic hit = hrd || (host_rd_in && host_addr_in == CMD_PORT); // any decoded read
   wire logic kwr = core_wr_in && core_addr_in == `KBC_OFS_KBD_OUT; // keyboard port write
   wire logic awr = core_wr_in && core_addr_in == `KBC_OFS_AUX_OUT; // mouse port write
   // follow core writes of the two control registers
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctl <= 4'h0;
         inv <= 1'b0;
         lvl <= 2'b11;
      end else if (core_wr_in && core_addr_in == `KBC_OFS_IF_CONTROL) begin
         ctl <= core_wdata_in[3:0];
      end else if (core_wr_in && core_addr_in == `KBC_OFS_IRQ_CONTROL) begin
         inv <= core_wdata_in[6];
         lvl <= core_wdata_in[1:0];
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   a_read_answer: assert property (hit |=> host_rvalid_out && $past(hit))
      else $error("host read not answered");
   a_kbd_write_raise: assert property (kwr |=>
      (!ctl[0] || keyboard_host_irq_out != inv) && (!ctl[1] || mouse_host_irq_out == inv))
      else $error("keyboard port write line wrong");
   a_aux_write_raise: assert property (awr |=>
      (!ctl[1] || mouse_host_irq_out != inv) && (!ctl[0] || keyboard_host_irq_out == inv))
      else $error("mouse port write line wrong");
   a_read_drops_irq: assert property (hrd && !core_wr_in |=>
      (!ctl[0] || keyboard_host_irq_out == inv) && (!ctl[1] || mouse_host_irq_out == inv))
      else $error("host line not dropped by read");
   a_fw_levels: assert property ((ctl[0] || keyboard_host_irq_out == lvl[0]) &&
      (ctl[1] || mouse_host_irq_out == lvl[1]))
      else $error("firmware level not on line");
   a_infull_gate: assert property (core_infull_irq_out |-> ctl[3])
      else $error("input irq without enable");
   a_input_read_clear: assert property (core_rd_in && core_addr_in == `KBC_OFS_INPUT_READ
      && !core_wr_in && core_infull_irq_out |=> !core_infull_irq_out)
      else $error("input read kept full");
   a_outempty_on_read: assert property (hrd && ctl[2] && !core_wr_in |=> core_outempty_irq_out)
      else $error("empty irq missing after read");
   a_outfull_on_write: assert property (kwr || awr |=> !core_outempty_irq_out)
      else $error("empty irq after output write");
   c_kbd_read: cover property (hrd && ctl[0]);
   c_aux_read: cover property (hrd && ctl[1]);
   c_input_cycle: cover property (core_infull_irq_out ##1 !core_infull_irq_out);
endmodule
bind kbc_host_channel kbc_host_channel_props #(.DATA_PORT(DATA_PORT), .CMD_PORT(CMD_PORT))
   kbc_host_channel_props_inst (.core_clk_in, .reset_n_in, .host_addr_in, .host_rd_in,
   .host_rvalid_out, .core_addr_in, .core_wr_in, .core_rd_in, .core_wdata_in,
   .core_infull_irq_out, .core_outempty_irq_out, .keyboard_host_irq_out, .mouse_host_irq_out);
`default_nettype wire

// *** testbench/kbc_host_model.sv ***
// Purpose: host processor doing legacy I/O cycles on the channel
// Assumes: signals change just after rising edges
// Notes: idle address and data show the inverse of the last value
`default_nettype none
`include "kbc_regs.svh"
module kbc_host_model (
   input wire logic core_clk_in,
   output logic [15:0] host_addr_out,
   output logic host_wr_out,
   output logic host_rd_out,
   output kbc_pkg::kbc_byte_t host_wdata_out,
   input wire kbc_pkg::kbc_byte_t host_rdata_in,
   input wire logic host_rvalid_in,
   input wire logic host_wr_ready_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import kbc_pkg::*;
   int idle_cycles = 0; // extra edges before each cycle, a slow host
   initial begin
      host_addr_out = 16'h0000;
      host_wr_out = 1'b0;
      host_rd_out = 1'b0;
      host_wdata_out = 8'h00;
   end
   // write held until the channel has room
   task automatic put(input logic [15:0] a, input kbc_byte_t d, output logic ok);
      int n;
      ok = 1'b0;
      repeat (idle_cycles + 1) @(posedge core_clk_in);
      host_addr_out <= a;
      host_wdata_out <= d;
      host_wr_out <= 1'b1;
      for (n = 0; n < 200 && !ok; n++) begin
         @(posedge core_clk_in);
         ok = host_wr_ready_in;
      end
      host_wr_out <= 1'b0;
      host_addr_out <= ~a;
      host_wdata_out <= ~d;
   endtask
   // one-cycle read strobe, answer taken a cycle later
   task automatic get(input logic [15:0] a, output kbc_byte_t d, output logic ok);
      repeat (idle_cycles + 1) @(posedge core_clk_in);
      host_addr_out <= a;
      host_rd_out <= 1'b1;
      @(posedge core_clk_in);
      host_rd_out <= 1'b0;
      host_addr_out <= ~a;
      @(posedge core_clk_in);
      d = host_rdata_in;
      ok = host_rvalid_in;
   endtask
   // poll status for output-full up to 20 times, then read data
   task automatic fetch(output kbc_byte_t d, output logic ok);
      kbc_byte_t st;
      int n;
      st = 8'h00;
      for (n = 0; n < 20 && st[0] !== 1'b1; n++) get(`KBC_HOST_CMD_PORT, st, ok);
      get(`KBC_HOST_DATA_PORT, d, ok);
      ok = ok && st[0];
   endtask
endmodule
`default_nettype wire
